// file: fsc_pkg.sv
// Package with field layout, reset values and carrier types for the FPU regs
package fsc_pkg;

  // ----------------------------------------------------------------
  // Status/control field positions
  // ----------------------------------------------------------------
  localparam int RSV_HI     = 31;
  localparam int RSV_LO     = 22;
  localparam int BANK_POS   = 21;
  localparam int PAIR_POS   = 20;
  localparam int DBL_POS    = 19;
  localparam int FLUSH_POS  = 18;
  localparam int CAUSE_HI   = 17;
  localparam int CAUSE_LO   = 12;
  localparam int EN_HI      = 11;
  localparam int EN_LO      = 7;
  localparam int FLAG_HI    = 6;
  localparam int FLAG_LO    = 2;
  localparam int RND_HI     = 1;
  localparam int RND_LO     = 0;

  // Exception source index inside a six-bit source vector
  localparam int SRC_ERR    = 5;
  localparam int SRC_INV    = 4;
  localparam int SRC_DIV0   = 3;
  localparam int SRC_OVF    = 2;
  localparam int SRC_UNF    = 1;
  localparam int SRC_INX    = 0;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic       BANK_RST  = 1'h0;
  localparam logic       PAIR_RST  = 1'h0;
  localparam logic       DBL_RST   = 1'h0;
  localparam logic       FLUSH_RST = 1'h1;
  localparam logic [5:0] CAUSE_RST = 6'h00;
  localparam logic [4:0] EN_RST    = 5'h00;
  localparam logic [4:0] FLAG_RST  = 5'h00;
  localparam logic [1:0] RND_RST   = 2'h1;
  localparam logic [1:0] RND_NEAR  = 2'h0;
  localparam logic [1:0] RND_ZERO  = 2'h1;
  localparam logic [9:0] RSV_VAL   = 10'h000;
  localparam logic [31:0] WORD_RST = 32'h00000000;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        sel_status;  // Access targets the status/control word
    logic        sel_word;    // Access targets the transfer word
    logic        wr;          // Store-system (write) strobe
    logic        rd;          // Load-system (read) strobe
    logic [31:0] wdata;       // Write data
  } fsc_core_req_t;

  typedef struct packed {
    logic       bank_swap;    // Bank roles swapped
    logic       pair;         // Float moves carry 64-bit pairs
    logic       dbl;          // Double-precision execution
    logic       flush;        // Denormals treated as zero
    logic [1:0] rnd;          // Rounding select
  } fsc_mode_t;

endpackage

// file: fsc_regs.sv
// FPU status/control register and CPU-to-FPU transfer word
`timescale 1ns/1ns

module fsc_regs
  import fsc_pkg::*;
(
  input  wire logic          sys_clk,       // 100 MHz clock
  input  wire logic          rst,           // Async reset, active high
  input  wire fsc_core_req_t core_req,      // Core system load/store
  output logic [31:0]        core_rdata,    // Read data, registered
  output logic               core_rvalid,   // Read data valid pulse
  input  wire logic          op_exec,       // FPU operation executes
  input  wire logic [5:0]    op_exc,        // Sources E,V,Z,O,U,I
  input  wire logic          fpu_word_wr,   // FPU writes transfer word
  input  wire logic [31:0]   fpu_word_wdata,// FPU write data
  output logic [31:0]        fpu_word,      // Transfer word value
  output fsc_mode_t          mode,          // Current mode bits
  output logic               primary_bank,  // Bank behind primary view
  output logic               extended_bank, // Bank behind extended view
  output logic               gfx_undefined, // Graphics ops undefined
  output logic               exc_req        // Exception handling pulse
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic        bank_ff;
  logic        pair_ff;
  logic        dbl_ff;
  logic        flush_ff;
  logic [1:0]  rnd_ff;
  logic [5:0]  cause_ff;
  logic [4:0]  en_ff;
  logic [4:0]  flag_ff;
  logic [31:0] word_ff;
  logic [31:0] rdata_ff;
  logic        rvalid_ff;
  logic        exc_ff;

  logic [5:0]  nxt_cause;
  logic [4:0]  nxt_flag;
  logic [5:0]  src;
  logic        stat_wr;
  logic        word_wr;
  logic        nxt_exc;

  // Assemble the visible status word; reserved bits forced to zero
  function automatic logic [31:0] pack_status(
    input logic       bank,
    input logic       pair,
    input logic       dbl,
    input logic       flush,
    input logic [5:0] cause,
    input logic [4:0] en,
    input logic [4:0] flag,
    input logic [1:0] rnd
  );
    logic [31:0] w;
    w = 32'h00000000;
    w[RSV_HI:RSV_LO]     = RSV_VAL;
    w[BANK_POS]          = bank;
    w[PAIR_POS]          = pair;
    w[DBL_POS]           = dbl;
    w[FLUSH_POS]         = flush;
    w[CAUSE_HI:CAUSE_LO] = cause;
    w[EN_HI:EN_LO]       = en;
    w[FLAG_HI:FLAG_LO]   = flag;
    w[RND_HI:RND_LO]     = rnd;
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign stat_wr = core_req.wr & core_req.sel_status;
  assign word_wr = core_req.wr & core_req.sel_word;

  // Error source only exists while denormals are kept as such
  always_comb begin
    src          = op_exc;
    src[SRC_ERR] = op_exc[SRC_ERR] & ~flush_ff;
  end

  // ----------------------------------------------------------------
  // Mode bits
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bank_ff  <= BANK_RST;
      pair_ff  <= PAIR_RST;
      dbl_ff   <= DBL_RST;
      flush_ff <= FLUSH_RST;
      rnd_ff   <= RND_RST;
    end else if (stat_wr) begin
      bank_ff  <= core_req.wdata[BANK_POS];
      pair_ff  <= core_req.wdata[PAIR_POS];
      dbl_ff   <= core_req.wdata[DBL_POS];
      flush_ff <= core_req.wdata[FLUSH_POS];
      rnd_ff   <= core_req.wdata[RND_HI:RND_LO];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      en_ff <= EN_RST;
    end else if (stat_wr) begin
      en_ff <= core_req.wdata[EN_HI:EN_LO];
    end
  end

  // ----------------------------------------------------------------
  // Cause and flag fields
  // ----------------------------------------------------------------
  // An event in the cycle of a software write is ORed on top, so a
  // write of zero can never swallow a fresh exception.
  always_comb begin
    if (stat_wr) begin
      nxt_cause = core_req.wdata[CAUSE_HI:CAUSE_LO];
    end else if (op_exec) begin
      nxt_cause = CAUSE_RST;
    end else begin
      nxt_cause = cause_ff;
    end
    if (stat_wr) begin
      nxt_flag = core_req.wdata[FLAG_HI:FLAG_LO];
    end else begin
      nxt_flag = flag_ff;
    end
    if (op_exec) begin
      nxt_cause = nxt_cause | src;
      nxt_flag  = nxt_flag | src[SRC_INV:SRC_INX];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cause_ff <= CAUSE_RST;
      flag_ff  <= FLAG_RST;
    end else begin
      cause_ff <= nxt_cause;
      flag_ff  <= nxt_flag;
    end
  end

  // ----------------------------------------------------------------
  // Exception request
  // ----------------------------------------------------------------
  // Error has no enable bit and therefore cannot be masked
  assign nxt_exc = op_exec &
                   (src[SRC_ERR] |
                    (|(src[SRC_INV:SRC_INX] & en_ff)));

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      exc_ff <= 1'h0;
    end else begin
      exc_ff <= nxt_exc;
    end
  end

  // ----------------------------------------------------------------
  // Transfer word
  // ----------------------------------------------------------------
  // Core store takes priority over an FPU write in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      word_ff <= WORD_RST;
    end else if (word_wr) begin
      word_ff <= core_req.wdata;
    end else if (fpu_word_wr) begin
      word_ff <= fpu_word_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Core read path
  // ----------------------------------------------------------------
  // Reads return the value before any same-cycle update
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_ff  <= 32'h00000000;
      rvalid_ff <= 1'h0;
    end else begin
      rvalid_ff <= core_req.rd &
                   (core_req.sel_status | core_req.sel_word);
      if (core_req.rd & core_req.sel_status) begin
        rdata_ff <= pack_status(bank_ff, pair_ff, dbl_ff, flush_ff,
                                cause_ff, en_ff, flag_ff, rnd_ff);
      end else if (core_req.rd & core_req.sel_word) begin
        rdata_ff <= word_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign core_rdata     = rdata_ff;
  assign core_rvalid    = rvalid_ff;
  assign fpu_word       = word_ff;
  assign mode.bank_swap = bank_ff;
  assign mode.pair      = pair_ff;
  assign mode.dbl       = dbl_ff;
  assign mode.flush     = flush_ff;
  assign mode.rnd       = rnd_ff;
  assign primary_bank   = bank_ff;
  assign extended_bank  = ~bank_ff;
  assign gfx_undefined  = dbl_ff;
  assign exc_req        = exc_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_op_plain;
    op_exec && !stat_wr;
  endsequence

  sequence s_stat_read;
    core_req.rd && core_req.sel_status;
  endsequence

  a_rsv_read_zero: assert property (
    s_stat_read |=> core_rvalid && core_rdata[RSV_HI:RSV_LO] == RSV_VAL)
    else $error("reserved status bits read nonzero");

  a_bank_views: assert property (
    stat_wr |=> primary_bank == $past(core_req.wdata[BANK_POS]) &&
                extended_bank != primary_bank)
    else $error("bank views do not follow bank swap bit");

  a_pair_gfx: assert property (
    stat_wr |=> mode.pair == $past(core_req.wdata[PAIR_POS]) &&
                gfx_undefined == $past(core_req.wdata[DBL_POS]))
    else $error("pair or precision bit not loaded");

  a_flush_err: assert property (
    s_op_plain ##0 (flush_ff && op_exc == 6'h20) |=>
      cause_ff == 6'h00 && !exc_req)
    else $error("error source raised while flushing denormals");

  a_cause_clear: assert property (
    s_op_plain |=> cause_ff == $past(src))
    else $error("cause field not replaced on operation");

  a_flag_sticky: assert property (
    !stat_wr |=> (flag_ff & $past(flag_ff)) == $past(flag_ff))
    else $error("sticky flag lost without software write");

  a_flag_set: assert property (
    op_exec |=> (flag_ff & $past(src[SRC_INV:SRC_INX])) ==
                $past(src[SRC_INV:SRC_INX]))
    else $error("exception did not set its flag");

  a_err_unmasked: assert property (
    op_exec && src[SRC_ERR] |=> exc_req ##1 (!exc_req || $past(op_exec)))
    else $error("fpu error did not raise exception");

  a_masked_quiet: assert property (
    op_exec && !src[SRC_ERR] && (src[SRC_INV:SRC_INX] & en_ff) == 5'h00
      |=> !exc_req)
    else $error("masked exception raised handling");

  a_rnd_reset: assert property (
    $fell(rst) |-> mode.rnd == RND_ZERO && mode.flush)
    else $error("rounding or flush reset value wrong");

  a_word_store: assert property (
    word_wr |=> fpu_word == $past(core_req.wdata))
    else $error("transfer word store not taken");

  a_word_read: assert property (
    core_req.rd && core_req.sel_word && !core_req.sel_status
      |=> core_rdata == $past(fpu_word))
    else $error("transfer word readback mismatch");

  a_enabled_raise: assert property (
    op_exec && (src[SRC_INV:SRC_INX] & en_ff) != 5'h00 |=> exc_req)
    else $error("enabled exception did not raise handling");

  // A write landing with an operation must not swallow the new cause
  a_cause_wr_set: assert property (
    op_exec && stat_wr |=> (cause_ff & $past(src)) == $past(src))
    else $error("write in operation cycle lost a cause bit");

  a_no_sel_quiet: assert property (
    !(core_req.rd && (core_req.sel_status || core_req.sel_word))
      |=> !core_rvalid)
    else $error("read valid without a selected read");

endmodule

// file: fsc_core_model.sv
// Core-side model: system load/store and FPU operation issue
`timescale 1ns/1ns
module fsc_core_model
  import fsc_pkg::*;
(
  input  wire logic          sys_clk,        // System clock
  output fsc_core_req_t      core_req,       // System load/store request
  input  wire logic [31:0]   core_rdata,     // Read data
  input  wire logic          core_rvalid,    // Read data valid
  output logic               op_exec,        // Operation issue pulse
  output logic [5:0]         op_exc,         // Exception sources
  output logic               fpu_word_wr,    // FPU transfer word write
  output logic [31:0]        fpu_word_wdata, // FPU write data
  input  wire logic          exc_req         // Exception handling request
);
  initial begin
    core_req = '0;
    op_exec = 1'b0;
    op_exc = 6'h00;
    fpu_word_wr = 1'b0;
    fpu_word_wdata = 32'h00000000;
  end

  // ----------------------------------------------------------------
  // Load/store-system access; only the store path may clear sticky flags
  // ----------------------------------------------------------------
  task automatic wr_reg(input logic st, input logic [31:0] d);
    @(posedge sys_clk);
    core_req <= '{st, !st, 1'b1, 1'b0, d};
    @(posedge sys_clk);
    // Idle bus shows the inverse so stale data is never mistaken
    core_req <= '{1'b0, 1'b0, 1'b0, 1'b0, ~d};
  endtask

  task automatic rd_reg(input logic st, output logic [31:0] d,
                        output logic v);
    @(posedge sys_clk);
    core_req <= '{st, !st, 1'b0, 1'b1, ~core_req.wdata};
    @(posedge sys_clk);
    core_req <= '{1'b0, 1'b0, 1'b0, 1'b0, core_req.wdata};
    #1;
    d = core_rdata;
    v = core_rvalid;
  endtask

  // ----------------------------------------------------------------
  // FPU operation issue; sources are junk outside the pulse
  // ----------------------------------------------------------------
  task automatic fpu_op(input logic [5:0] exc, output logic req);
    @(posedge sys_clk);
    op_exec <= 1'b1;
    op_exc <= exc;
    @(posedge sys_clk);
    op_exec <= 1'b0;
    op_exc <= ~exc;
    #1;
    req = exc_req;
  endtask

  task automatic fpu_wr(input logic [31:0] d);
    @(posedge sys_clk);
    fpu_word_wr <= 1'b1;
    fpu_word_wdata <= d;
    @(posedge sys_clk);
    fpu_word_wr <= 1'b0;
    fpu_word_wdata <= ~d;
  endtask
endmodule

// file: fsc_regs_tb.sv
// Self-checking bench for the FPU status/control and transfer word regs
`timescale 1ns/1ns
module fsc_regs_tb
  import fsc_pkg::*;
;
  logic          sys_clk;
  logic          rst;
  fsc_core_req_t core_req;
  logic [31:0]   core_rdata;
  logic          core_rvalid;
  logic          op_exec;
  logic [5:0]    op_exc;
  logic          fpu_word_wr;
  logic [31:0]   fpu_word_wdata;
  logic [31:0]   fpu_word;
  fsc_mode_t     mode;
  logic          primary_bank;
  logic          extended_bank;
  logic          gfx_undefined;
  logic          exc_req;
  int            bad_count;
  int            compares;
  logic [31:0]   rd_val;
  logic          rd_ok;
  logic          req;
  logic [4:0]    flags;
  logic [31:0]   exp;

  always #5 sys_clk = ~sys_clk;

  fsc_regs dut_u (.sys_clk(sys_clk), .rst(rst), .core_req(core_req),
    .core_rdata(core_rdata), .core_rvalid(core_rvalid),
    .op_exec(op_exec), .op_exc(op_exc), .fpu_word_wr(fpu_word_wr),
    .fpu_word_wdata(fpu_word_wdata), .fpu_word(fpu_word), .mode(mode),
    .primary_bank(primary_bank), .extended_bank(extended_bank),
    .gfx_undefined(gfx_undefined), .exc_req(exc_req));

  fsc_core_model core_u (.sys_clk(sys_clk), .core_req(core_req),
    .core_rdata(core_rdata), .core_rvalid(core_rvalid),
    .op_exec(op_exec), .op_exc(op_exc), .fpu_word_wr(fpu_word_wr),
    .fpu_word_wdata(fpu_word_wdata), .exc_req(exc_req));

  // ----------------------------------------------------------------
  // Compare and report
  // ----------------------------------------------------------------
  task automatic chk32(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic rd_chk(input logic st, input logic [31:0] e,
                        input string nm);
    core_u.rd_reg(st, rd_val, rd_ok);
    chk1({nm, " valid"}, 1'b1, rd_ok);
    chk32(nm, e, rd_val);
  endtask

  // Mode outputs and the derived bank and graphics views together
  task automatic chk_mode(input logic [5:0] m);
    chk32("mode", {26'h0, m}, {26'h0, mode});
    chk1("primary_bank", m[5], primary_bank);
    chk1("extended_bank", !m[5], extended_bank);
    chk1("gfx_undefined", m[3], gfx_undefined);
  endtask

  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    report_and_stop;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    bad_count = 0;
    compares = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk_mode(6'h05);
    chk1("exc_req", 1'b0, exc_req);
    chk32("fpu_word", 32'h00000000, fpu_word);
    rd_chk(1'b1, 32'h00040001, "status");
    rd_chk(1'b0, 32'h00000000, "word");
    core_u.wr_reg(1'b1, 32'h003C0F82);
    rd_chk(1'b1, 32'h003C0F82, "status");
    chk_mode(6'h3E);
    // Reserved bits written as ones must not stick
    core_u.wr_reg(1'b1, 32'hFFC00001);
    rd_chk(1'b1, 32'h00000001, "status");
    chk_mode(6'h01);
    flags = 5'h00;
    for (int i = 0; i < 6; i++) begin
      core_u.fpu_op(6'h01 << i, req);
      if (i < 5) flags[i] = 1'b1;
      chk1("exc_req", (i == 5), req);
      exp = (32'h1 << (CAUSE_LO + i)) | ({27'h0, flags} << FLAG_LO) | 32'h1;
      rd_chk(1'b1, exp, "status");
    end
    core_u.fpu_op(6'h00, req);
    chk1("exc_req", 1'b0, req);
    rd_chk(1'b1, 32'h0000007D, "status");
    core_u.wr_reg(1'b1, 32'h00000F81);
    rd_chk(1'b1, 32'h00000F81, "status");
    for (int i = 0; i < 5; i++) begin
      core_u.fpu_op(6'h01 << i, req);
      chk1("exc_req", 1'b1, req);
    end
    rd_chk(1'b1, 32'h00010FFD, "status");
    core_u.wr_reg(1'b0, 32'hA5C30F1E);
    rd_chk(1'b0, 32'hA5C30F1E, "word");
    chk32("fpu_word", 32'hA5C30F1E, fpu_word);
    core_u.fpu_wr(32'h12345678);
    rd_chk(1'b0, 32'h12345678, "word");
    rd_chk(1'b1, 32'h00010FFD, "status");
    // Clear and event in one cycle: the event must survive the write
    fork
      core_u.wr_reg(1'b1, 32'h00000000);
      core_u.fpu_op(6'h02, req);
    join
    chk1("exc_req", 1'b1, req);
    rd_chk(1'b1, 32'h00002008, "status");
    chk_mode(6'h00);
    core_u.wr_reg(1'b1, 32'h00040000);
    core_u.fpu_op(6'h20, req);
    chk1("exc_req", 1'b0, req);
    rd_chk(1'b1, 32'h00040000, "status");
    report_and_stop;
  end
endmodule
